/* File: verilog/scpm_pkg.sv */
// constants and helper functions shared by the clock manager files
package scpm_pkg;

  localparam int          SCPM_PRESC_W      = 8;
  localparam int          SCPM_EXP_W        = 3;
  localparam int          SCPM_APB_DOMAINS  = 3;
  localparam int          SCPM_GATE_W       = 16;
  localparam int          SCPM_CAUSE_W      = 8;

  localparam logic [SCPM_PRESC_W-1:0] SCPM_PRESC_RESET = 8'h00;
  localparam logic [SCPM_PRESC_W-1:0] SCPM_PRESC_LAST  = 8'hFF;
  localparam logic [SCPM_EXP_W-1:0]   SCPM_EXP_RESET   = 3'h0;

  // gate layout: ahb bit 0 feeds the bridge in front of the manager,
  // apb domain 0 bit 1 is the manager's own bus clock
  localparam int SCPM_AHB_BRIDGE_BIT = 0;
  localparam int SCPM_MGR_BUS_BIT    = 1;
  localparam int SCPM_MGR_DOMAIN     = 0;

  localparam logic [SCPM_GATE_W-1:0] SCPM_AHB_GATE_RESET  = 16'h003F;
  localparam logic [SCPM_GATE_W-1:0] SCPM_APBA_GATE_RESET = 16'h007F;
  localparam logic [SCPM_GATE_W-1:0] SCPM_APBB_GATE_RESET = 16'h003F;
  localparam logic [SCPM_GATE_W-1:0] SCPM_APBC_GATE_RESET = 16'h0080;

  localparam logic [SCPM_CAUSE_W-1:0] SCPM_CAUSE_POR = 8'h01;

  localparam logic                    SCPM_SETTLED_RESET = 1'b1;
  localparam logic                    SCPM_IRQ_EN_RESET  = 1'b0;

  // one-cycle enable of the prescaler tap that divides by 2**e
  function automatic logic scpm_tap(
    input logic [SCPM_PRESC_W-1:0] count,
    input logic [SCPM_EXP_W-1:0]   e
  );
    logic [SCPM_PRESC_W-1:0] mask;
    mask = (SCPM_PRESC_W)'((9'h001 << e) - 9'h001);
    return (count & mask) == mask;
  endfunction

  // larger exponent of two, i.e. the slower of two taps
  function automatic logic [SCPM_EXP_W-1:0] scpm_slower(
    input logic [SCPM_EXP_W-1:0] a,
    input logic [SCPM_EXP_W-1:0] b
  );
    return (a > b) ? a : b;
  endfunction

endpackage

/* File: verilog/scpm_prescaler.sv */
// shared free-running prescaler counter of the main clock
`timescale 1ns/1ps
`default_nettype none
module scpm_prescaler
  import scpm_pkg::*;
#(
  parameter int WIDTH = SCPM_PRESC_W
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  output logic [WIDTH-1:0]      count,
  output logic                  boundary
);

  initial begin
    if (WIDTH != SCPM_PRESC_W) $error("prescaler width must match package");
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      count <= SCPM_PRESC_RESET;
    end else begin
      count <= count + 1'b1;
    end
  end

  // every tap fires together here, so a divider swap never makes a runt
  assign boundary = (count == SCPM_PRESC_LAST);

endmodule
`default_nettype wire

/* File: verilog/scpm_gate_bank.sv */
// per-module clock gate bits of one clock domain
`timescale 1ns/1ps
`default_nettype none
module scpm_gate_bank
  import scpm_pkg::*;
#(
  parameter int               WIDTH       = SCPM_GATE_W,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic             domain_ce,
  output logic [WIDTH-1:0]      gate_bits,
  output logic [WIDTH-1:0]      module_ce
);

  initial begin
    if (WIDTH < 1 || WIDTH > 32) $error("gate bank width out of range");
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gate_bits <= RESET_VALUE;
    end else if (wr_en) begin
      gate_bits <= wdata;
    end
  end

  // one bit per module and domain; a multi-domain module owns a bit here
  assign module_ce = {WIDTH{domain_ce}} & gate_bits;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_gate_write;
    wr_en |=> gate_bits == $past(wdata);
  endproperty
  a_gate_write: assert property (p_gate_write) else $error("gate write lost");

  // no module may tick between domain pulses, whatever its gate says
  property p_gate_cut;
    !domain_ce |-> module_ce == '0;
  endproperty
  a_gate_cut: assert property (p_gate_cut) else $error("module clocked off its domain");

  property p_gate_off_silent;
    (!wr_en && gate_bits == '0) |=> module_ce == '0;
  endproperty
  a_gate_off_silent: assert property (p_gate_off_silent) else $error("gated module still clocked");

endmodule
`default_nettype wire

/* File: verilog/scpm_top.sv */
// synchronous clock divider, gating and settle flag of the power manager
`timescale 1ns/1ps
`default_nettype none
module scpm_top
  import scpm_pkg::*;
#(
  parameter int ND = SCPM_APB_DOMAINS,
  parameter int GW = SCPM_GATE_W
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire logic                  proc_divider_select_wr,
  input  wire logic [SCPM_EXP_W-1:0] proc_divider_select_wdata,
  input  wire logic [ND-1:0]         apb_divider_select_wr,
  input  wire logic [ND*SCPM_EXP_W-1:0] apb_divider_select_wdata,
  input  wire logic                  ahb_gate_wr,
  input  wire logic [GW-1:0]         ahb_gate_wdata,
  input  wire logic [ND-1:0]         apb_gate_wr,
  input  wire logic [ND*GW-1:0]      apb_gate_wdata,
  input  wire logic                  irq_enable_set,
  input  wire logic                  irq_enable_clr,
  input  wire logic                  interrupt_flag_clr,
  input  wire logic                  guard_protect,
  input  wire logic                  debugger_access,
  input  wire logic                  cpu_sleep,
  input  wire logic                  debug_active,
  output logic [SCPM_EXP_W-1:0]      processor_divide_exponent,
  output logic [ND*SCPM_EXP_W-1:0]   apb_divide_exponent,
  output logic                       clocks_settled_flag,
  output logic                       settle_pending,
  output logic                       irq_enabled,
  output logic                       irq,
  output logic                       gates_locked,
  output logic [GW-1:0]              ahb_gate_bits,
  output logic [ND*GW-1:0]           apb_gate_bits,
  output logic                       cpu_clock_ce,
  output logic                       ahb_clock_ce,
  output logic [ND-1:0]              apb_domain_clock_ce,
  output logic [GW-1:0]              ahb_module_ce,
  output logic [ND*GW-1:0]           apb_module_ce,
  output logic [ND*GW-1:0]           apb_access_ok,
  output logic [SCPM_CAUSE_W-1:0]    last_reset_cause,
  output logic [SCPM_PRESC_W-1:0]    prescaler_count
);

  initial begin
    if (ND != SCPM_APB_DOMAINS) $error("apb domain count must be three");
    if (GW != SCPM_GATE_W) $error("gate width must match package");
  end

  logic                       boundary;
  logic                       guard_ok;
  logic                       write_ok;
  logic                       div_wr_ok;
  logic                       apply;
  logic [SCPM_EXP_W-1:0]      pend_proc;
  logic [ND*SCPM_EXP_W-1:0]   pend_apb;
  logic                       cpu_run;
  logic                       gate_wr_ok;

  // the one shared divider chain
  scpm_prescaler #(
    .WIDTH    (SCPM_PRESC_W)
  ) u_presc (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .count    (prescaler_count),
    .boundary (boundary)
  );

  // writes other than the flag clear die once the manager's own clock path is gone
  assign write_ok = !gates_locked;
  // debugger accesses always pass the guard
  assign guard_ok = !guard_protect || debugger_access;
  assign div_wr_ok = write_ok && guard_ok &&
                     (proc_divider_select_wr || (|apb_divider_select_wr));
  assign gate_wr_ok = write_ok && guard_ok;
  // a write landing on the boundary waits for the next one
  assign apply = settle_pending && boundary && !div_wr_ok;

  // staging of divider selections until the boundary
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pend_proc <= SCPM_EXP_RESET;
      pend_apb  <= {ND{SCPM_EXP_RESET}};
    end else if (div_wr_ok) begin
      if (proc_divider_select_wr) begin
        pend_proc <= proc_divider_select_wdata;
      end
      for (int d = 0; d < ND; d++) begin
        if (apb_divider_select_wr[d]) begin
          pend_apb[d*SCPM_EXP_W +: SCPM_EXP_W] <=
            apb_divider_select_wdata[d*SCPM_EXP_W +: SCPM_EXP_W];
        end
      end
    end
  end

  // all domains switch on the same edge; untouched ones keep old value
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      processor_divide_exponent <= SCPM_EXP_RESET;
      apb_divide_exponent       <= {ND{SCPM_EXP_RESET}};
    end else if (apply) begin
      processor_divide_exponent <= pend_proc;
      apb_divide_exponent       <= pend_apb;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      settle_pending <= 1'b0;
    end else if (div_wr_ok) begin
      settle_pending <= 1'b1;
    end else if (apply) begin
      settle_pending <= 1'b0;
    end
  end

  // settle event beats a simultaneous clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      clocks_settled_flag <= SCPM_SETTLED_RESET;
    end else if (apply) begin
      clocks_settled_flag <= 1'b1;
    end else if (div_wr_ok) begin
      clocks_settled_flag <= 1'b0;
    end else if (interrupt_flag_clr) begin
      clocks_settled_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_enabled <= SCPM_IRQ_EN_RESET;
    end else if (write_ok && guard_ok && irq_enable_set) begin
      irq_enabled <= 1'b1;
    end else if (write_ok && guard_ok && irq_enable_clr) begin
      irq_enabled <= 1'b0;
    end
  end

  assign irq = clocks_settled_flag && irq_enabled;

  // only rst clears this; no register path reopens the gates
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gates_locked <= 1'b0;
    end else if (!apb_gate_bits[SCPM_MGR_DOMAIN*GW + SCPM_MGR_BUS_BIT] ||
                 !ahb_gate_bits[SCPM_AHB_BRIDGE_BIT]) begin
      gates_locked <= 1'b1;
    end
  end

  // the manager has no enable or reset of its own, rst is the system's
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      last_reset_cause <= SCPM_CAUSE_POR;
    end
  end

  // debug keeps the processor clocked even when asleep
  assign cpu_run = !cpu_sleep || debug_active;
  assign ahb_clock_ce = scpm_tap(prescaler_count,
                                 processor_divide_exponent);
  assign cpu_clock_ce = ahb_clock_ce && cpu_run;

  // apb never faster than the processor, whatever software wrote
  always_comb begin
    for (int d = 0; d < ND; d++) begin
      apb_domain_clock_ce[d] = scpm_tap(prescaler_count,
        scpm_slower(apb_divide_exponent[d*SCPM_EXP_W +: SCPM_EXP_W],
                    processor_divide_exponent));
    end
  end

  scpm_gate_bank #(
    .WIDTH       (GW),
    .RESET_VALUE (SCPM_AHB_GATE_RESET)
  ) u_ahb_gate (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .wr_en       (gate_wr_ok && ahb_gate_wr),
    .wdata       (ahb_gate_wdata),
    .domain_ce   (ahb_clock_ce),
    .gate_bits   (ahb_gate_bits),
    .module_ce   (ahb_module_ce)
  );

  localparam logic [ND*GW-1:0] APB_RESET =
    {SCPM_APBC_GATE_RESET, SCPM_APBB_GATE_RESET, SCPM_APBA_GATE_RESET};

  for (genvar d = 0; d < ND; d++) begin : g_apb
    scpm_gate_bank #(
      .WIDTH       (GW),
      .RESET_VALUE (APB_RESET[d*GW +: GW])
    ) u_apb_gate (
      .clk_sys     (clk_sys),
      .rst         (rst),
      .wr_en       (gate_wr_ok && apb_gate_wr[d]),
      .wdata       (apb_gate_wdata[d*GW +: GW]),
      .domain_ce   (apb_domain_clock_ce[d]),
      .gate_bits   (apb_gate_bits[d*GW +: GW]),
      .module_ce   (apb_module_ce[d*GW +: GW])
    );
  end

  // peripherals qualify register accesses with this level
  assign apb_access_ok = apb_gate_bits;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_lock_sticky;
    gates_locked |=> gates_locked;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock released");

  property p_locked_gates;
    gates_locked |=> $stable(ahb_gate_bits) && $stable(apb_gate_bits);
  endproperty
  a_locked_gates: assert property (p_locked_gates) else $error("gate changed while locked");

  property p_write_unsettles;
    div_wr_ok |=> !clocks_settled_flag && settle_pending;
  endproperty
  a_write_unsettles: assert property (p_write_unsettles) else $error("flag not dropped");

  property p_apply_lands;
    settle_pending && !div_wr_ok && prescaler_count == SCPM_PRESC_LAST
      |=> clocks_settled_flag && !settle_pending && prescaler_count == 8'h00;
  endproperty
  a_apply_lands: assert property (p_apply_lands) else $error("apply missed boundary");

  property p_settle_bounded;
    $rose(settle_pending) ##1 (!div_wr_ok)[*8] |-> ##[0:256] !settle_pending;
  endproperty
  a_settle_bounded: assert property (p_settle_bounded) else $error("settle never came");

  property p_irq_on_settle;
    apply && irq_enabled && !irq_enable_clr |=> irq;
  endproperty
  a_irq_on_settle: assert property (p_irq_on_settle) else $error("no interrupt");

  property p_cpu_halted;
    cpu_sleep && !debug_active |-> !cpu_clock_ce;
  endproperty
  a_cpu_halted: assert property (p_cpu_halted) else $error("cpu clocked in sleep");

  property p_debug_runs;
    debug_active |-> cpu_clock_ce == ahb_clock_ce;
  endproperty
  a_debug_runs: assert property (p_debug_runs) else $error("debug stopped clock");

  property p_apb_not_faster;
    |apb_domain_clock_ce |-> ahb_clock_ce;
  endproperty
  a_apb_not_faster: assert property (p_apb_not_faster) else $error("apb faster than cpu");

  property p_half_rate;
    processor_divide_exponent == 3'h1 && ahb_clock_ce && !apply
      |=> !ahb_clock_ce ##1 ahb_clock_ce;
  endproperty
  a_half_rate: assert property (p_half_rate) else $error("wrong divide by two");

  property p_guard_blocks;
    guard_protect && !debugger_access && !settle_pending
      |=> !settle_pending && $stable(irq_enabled);
  endproperty
  a_guard_blocks: assert property (p_guard_blocks) else $error("guarded write passed");

  property p_w1c;
    interrupt_flag_clr && !apply |=> !clocks_settled_flag;
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared");

  c_apply:   cover property (apply);
  c_lock:    cover property ($rose(gates_locked));
  c_irq:     cover property ($rose(irq));
  c_blocked: cover property (guard_protect && !debugger_access &&
                             proc_divider_select_wr);

endmodule
`default_nettype wire

/* File: tb/scpm_partner.sv */
// far-side model: clock consumers and one gated peripheral register
`timescale 1ns/1ps
`default_nettype none
module scpm_partner (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        cpu_clock_ce,
  input  wire logic        ahb_clock_ce,
  input  wire logic [2:0]  apb_domain_clock_ce,
  input  wire logic [15:0] ahb_module_ce,
  input  wire logic [47:0] apb_access_ok,
  input  wire logic        cnt_clr,
  input  wire logic        per_wr,
  input  wire logic [7:0]  per_wdata,
  output logic [7:0]       per_rdata,
  output logic [15:0]      cpu_n,
  output logic [15:0]      ahb_n,
  output logic [15:0]      mod_n,
  output logic [47:0]      apb_n
);
  localparam int SLOT = 19;  // apb domain 1, module 3
  logic [7:0] per_reg;
  // consumers count the enables they get
  always_ff @(posedge clk_sys) begin
    if (rst || cnt_clr) begin
      cpu_n <= '0;
      ahb_n <= '0;
      mod_n <= '0;
      apb_n <= '0;
    end else begin
      cpu_n <= cpu_n + 16'(cpu_clock_ce);
      ahb_n <= ahb_n + 16'(ahb_clock_ce);
      mod_n <= mod_n + 16'(ahb_module_ce[5]);
      for (int d = 0; d < 3; d++) begin
        apb_n[16*d +: 16] <= apb_n[16*d +: 16] + 16'(apb_domain_clock_ce[d]);
      end
    end
  end
  // unclocked module ignores writes
  always_ff @(posedge clk_sys) begin
    if (rst)
      per_reg <= 8'h00;
    else if (per_wr && apb_access_ok[SLOT])
      per_reg <= per_wdata;
  end
  // no valid read while gated: show the inverse, never a stale value
  assign per_rdata = apb_access_ok[SLOT] ? per_reg : ~per_reg;
endmodule
`default_nettype wire

/* File: tb/scpm_tb_top.sv */
// self-checking bench of the synchronous clock manager
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("Error t=%0t got %h exp %h", $time, (g), (e)); end end
module scpm_tb_top;
  import scpm_pkg::*;
  logic        clk_sys, rst, proc_divider_select_wr, ahb_gate_wr;
  logic        irq_enable_set, irq_enable_clr, interrupt_flag_clr;
  logic        guard_protect, debugger_access, cpu_sleep, debug_active;
  logic        clocks_settled_flag, settle_pending, irq_enabled, irq;
  logic        gates_locked, cpu_clock_ce, ahb_clock_ce, per_wr, cnt_clr;
  logic        prev_settled, irq_on, locked;
  logic [2:0]  proc_divider_select_wdata, apb_divider_select_wr, cur_pe;
  logic [2:0]  apb_gate_wr, processor_divide_exponent, apb_domain_clock_ce;
  logic [8:0]  apb_divider_select_wdata, apb_divide_exponent, cur_ae;
  logic [15:0] ahb_gate_wdata, ahb_gate_bits, ahb_module_ce, exp_h, rh;
  logic [15:0] cpu_n, ahb_n, mod_n;
  logic [47:0] apb_gate_wdata, apb_gate_bits, apb_module_ce, ra;
  logic [47:0] apb_access_ok, apb_n, exp_a, exp_m;
  logic [7:0]  last_reset_cause, prescaler_count, per_wdata, per_rdata;
  logic [11:0] got;
  logic [11:0] exp_q[$];
  int          errors = 0;
  int          compares = 0;
  int          seed = 22151;

  scpm_top uut (
    .clk_sys, .rst, .proc_divider_select_wr, .proc_divider_select_wdata,
    .apb_divider_select_wr, .apb_divider_select_wdata, .ahb_gate_wr,
    .ahb_gate_wdata, .apb_gate_wr, .apb_gate_wdata, .irq_enable_set,
    .irq_enable_clr, .interrupt_flag_clr, .guard_protect, .debugger_access,
    .cpu_sleep, .debug_active, .processor_divide_exponent,
    .apb_divide_exponent, .clocks_settled_flag, .settle_pending,
    .irq_enabled, .irq, .gates_locked, .ahb_gate_bits, .apb_gate_bits,
    .cpu_clock_ce, .ahb_clock_ce, .apb_domain_clock_ce, .ahb_module_ce,
    .apb_module_ce, .apb_access_ok, .last_reset_cause, .prescaler_count
  );
  scpm_partner far_side (
    .clk_sys, .rst, .cpu_clock_ce, .ahb_clock_ce, .apb_domain_clock_ce,
    .ahb_module_ce, .apb_access_ok, .cnt_clr, .per_wr, .per_wdata,
    .per_rdata, .cpu_n, .ahb_n, .mod_n, .apb_n
  );

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // settle rise retires the oldest divider note
  always @(negedge clk_sys) begin
    if (!rst && clocks_settled_flag === 1'b1 && prev_settled === 1'b0) begin
      `CHK(exp_q.size() > 0, 1'b1)
      got = exp_q.pop_front();
      `CHK(({processor_divide_exponent, apb_divide_exponent}), got)
      `CHK(prescaler_count, 8'h00)
    end
    prev_settled = clocks_settled_flag;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic finish_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // software keeps every apb domain no faster than the processor
  function automatic logic [2:0] at_least(input logic [2:0] pe);
    return 3'(pe + $unsigned($random(seed)) % (8 - pe));
  endfunction

  // a domain dividing by 2**e ticks when the low e count bits are all one
  function automatic logic tap_hit(input logic [2:0] e);
    logic [7:0] m;
    m = 8'((9'h001 << e) - 9'h001);
    return (prescaler_count & m) == m;
  endfunction

  // a refused processor divider write must leave the settle state alone
  task automatic blocked_div;
    proc_divider_select_wr = 1'b1;
    proc_divider_select_wdata = 3'h5;
    cyc(1);
    proc_divider_select_wr = 1'b0;
    cyc(1);
    `CHK(({clocks_settled_flag, settle_pending, processor_divide_exponent}), 5'h10)
  endtask

  task automatic do_reset;
    rst = 1'b1;
    cyc(8);
    rst = 1'b0;
    cyc(1);
    exp_h = SCPM_AHB_GATE_RESET;
    exp_a = {SCPM_APBC_GATE_RESET, SCPM_APBB_GATE_RESET, SCPM_APBA_GATE_RESET};
    cur_pe = 3'h0;
    cur_ae = 9'h000;
    locked = 1'b0;
    `CHK(ahb_gate_bits, exp_h)
    `CHK(apb_gate_bits, exp_a)
    `CHK(last_reset_cause, SCPM_CAUSE_POR)
    `CHK(({processor_divide_exponent, apb_divide_exponent}), 12'h000)
    `CHK(({clocks_settled_flag, gates_locked, irq}), 3'h4)
  endtask

  task automatic set_div(input logic [2:0] pe, input logic [8:0] ae,
                         input logic on_edge);
    int k;
    for (k = 0; on_edge && k < 300 && prescaler_count !== 8'hFF; k++) cyc(1);
    if (on_edge && prescaler_count !== 8'hFF) begin
      errors++;
      finish_test();
    end
    exp_q.push_back({pe, ae});
    cur_pe = pe;
    cur_ae = ae;
    proc_divider_select_wr = 1'b1;
    proc_divider_select_wdata = pe;
    apb_divider_select_wr = 3'h7;
    apb_divider_select_wdata = ae;
    cyc(1);
    proc_divider_select_wr = 1'b0;
    apb_divider_select_wr = 3'h0;
    `CHK(clocks_settled_flag, 1'b0)
    // a write on the boundary postpones the apply a full turn
    for (k = 0; k < 600 && clocks_settled_flag !== 1'b1; k++) cyc(1);
    if (k == 600) begin
      errors++;
      finish_test();
    end
    `CHK(irq, irq_on)
  endtask

  task automatic rates(input logic cpu_on, input logic mod_on);
    cnt_clr = 1'b1;
    cyc(1);
    cnt_clr = 1'b0;
    cyc(256);
    `CHK(cpu_n, cpu_on ? 16'(256 >> cur_pe) : 16'h0000)
    `CHK(ahb_n, 16'(256 >> cur_pe))
    `CHK(mod_n, mod_on ? 16'(256 >> cur_pe) : 16'h0000)
    for (int d = 0; d < 3; d++)
      `CHK(apb_n[16*d +: 16], 16'(256 >> cur_ae[3*d +: 3]))
  endtask

  task automatic gate(input logic [15:0] h, input logic [47:0] a);
    logic ok;
    ok = !locked && (!guard_protect || debugger_access);
    ahb_gate_wr = 1'b1;
    ahb_gate_wdata = h;
    apb_gate_wr = 3'h7;
    apb_gate_wdata = a;
    cyc(1);
    ahb_gate_wr = 1'b0;
    apb_gate_wr = 3'h0;
    if (ok) begin
      exp_h = h;
      exp_a = a;
      locked = !h[SCPM_AHB_BRIDGE_BIT] || !a[SCPM_MGR_BUS_BIT];
    end
    cyc(1);
    `CHK(ahb_gate_bits, exp_h)
    `CHK(apb_gate_bits, exp_a)
    `CHK(apb_access_ok, exp_a)
    `CHK(gates_locked, locked)
    for (int d = 0; d < 3; d++)
      exp_m[16*d +: 16] = tap_hit(cur_ae[3*d +: 3]) ? exp_a[16*d +: 16] : 16'h0;
    `CHK(apb_module_ce, exp_m)
  endtask

  task automatic pulse_flag(input int which);
    irq_enable_set = (which == 0);
    irq_enable_clr = (which == 1);
    interrupt_flag_clr = (which == 2);
    cyc(1);
    {irq_enable_set, irq_enable_clr, interrupt_flag_clr} = 3'h0;
  endtask

  initial begin
    {proc_divider_select_wr, ahb_gate_wr, irq_enable_set, irq_enable_clr,
     interrupt_flag_clr, guard_protect, debugger_access, cpu_sleep,
     debug_active, per_wr, cnt_clr, proc_divider_select_wdata,
     apb_divider_select_wr, apb_divider_select_wdata, apb_gate_wr,
     ahb_gate_wdata, apb_gate_wdata, per_wdata} = '0;
    {prev_settled, irq_on, locked} = 3'h4;
    do_reset();
    rates(1'b1, 1'b1);
    $display("test reset_defaults done");
    for (int pe = 0; pe < 8; pe++) begin
      set_div(3'(pe), {at_least(3'(pe)), at_least(3'(pe)),
                       at_least(3'(pe))}, pe[0]);
      rates(1'b1, 1'b1);
    end
    $display("test divider_sweep done");
    pulse_flag(0);
    irq_on = 1'b1;
    set_div(3'h0, 9'h0C8, 1'b0);
    set_div(3'h1, 9'h049, 1'b0);
    guard_protect = 1'b1;
    pulse_flag(2);
    cyc(1);
    `CHK(({clocks_settled_flag, irq}), 2'h0)
    guard_protect = 1'b0;
    pulse_flag(1);
    irq_on = 1'b0;
    `CHK(irq_enabled, 1'b0)
    $display("test settle_irq done");
    cpu_sleep = 1'b1;
    rates(1'b0, 1'b1);
    debug_active = 1'b1;
    rates(1'b1, 1'b1);
    {cpu_sleep, debug_active} = 2'h0;
    $display("test sleep_debug done");
    rh = (16'($random(seed)) & 16'hFFDF) | 16'h0001;
    ra = (48'({$random(seed), $random(seed)}) & ~48'h80000) | 48'h2;
    per_wdata = 8'h5A;
    per_wr = 1'b1;
    cyc(1);
    per_wr = 1'b0;
    `CHK(per_rdata, 8'h5A)
    guard_protect = 1'b1;
    gate(rh, ra);
    debugger_access = 1'b1;
    gate(rh, ra);
    {guard_protect, debugger_access} = 2'h0;
    per_wdata = 8'h3C;
    per_wr = 1'b1;
    cyc(1);
    per_wr = 1'b0;
    `CHK(per_rdata, 8'hA5)
    rates(1'b1, 1'b0);
    gate(rh | 16'h0020, ra | 48'h80000);
    `CHK(per_rdata, 8'h5A)
    rates(1'b1, 1'b1);
    $display("test gates_guard done");
    gate(exp_h, exp_a & ~48'h2);
    gate(exp_h, exp_a | 48'h2);
    do_reset();
    guard_protect = 1'b1;
    blocked_div();
    guard_protect = 1'b0;
    gate(exp_h & 16'hFFFE, exp_a);
    gate(exp_h | 16'h0001, exp_a);
    blocked_div();
    do_reset();
    $display("test lock_reset done");
    finish_test();
  end
endmodule
`default_nettype wire
